/* hw/fill_pkg.sv */
// Shared constants and types of the bulk draft fill controller
package fill_pkg;

  localparam int CLK_HZ         = 100_000_000;
  localparam int SUSP_UNIT_MS   = 50;
  localparam int SETTLE_UNIT_MS = 100;
  localparam int TICK05_CYC     = CLK_HZ / 1000 * SUSP_UNIT_MS;
  localparam int T10_PER_T05    = SETTLE_UNIT_MS / SUSP_UNIT_MS;
  localparam int T05_PER_SEC    = 1000 / SUSP_UNIT_MS;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  localparam logic [7:0] A_CFG     = 8'h00;
  localparam logic [7:0] A_TARGET  = 8'h04;
  localparam logic [7:0] A_DRAFT   = 8'h08;
  localparam logic [7:0] A_MINDR   = 8'h0c;
  localparam logic [7:0] A_FINT    = 8'h10;
  localparam logic [7:0] A_FVAL    = 8'h14;
  localparam logic [7:0] A_SBAND   = 8'h18;
  localparam logic [7:0] A_SVAL    = 8'h1c;
  localparam logic [7:0] A_FSETTLE = 8'h20;
  localparam logic [7:0] A_SSETTLE = 8'h24;
  localparam logic [7:0] A_ZOFF    = 8'h28;
  localparam logic [7:0] A_KEYENT  = 8'h2c;
  localparam logic [7:0] A_CMD     = 8'h30;
  localparam logic [7:0] A_STATUS  = 8'h34;
  localparam logic [7:0] A_GROSS   = 8'h38;
  localparam logic [7:0] A_EACH    = 8'h3c;
  localparam logic [7:0] A_LAST    = 8'h40;
  localparam logic [7:0] A_FLEARN  = 8'h44;
  localparam logic [7:0] A_SLEARN  = 8'h48;
  localparam logic [7:0] A_ACC     = 8'h4c;

  localparam int CFG_LEVEL = 0;
  localparam int CFG_LEGAL = 1;
  localparam int CFG_TWO   = 2;
  localparam int CFG_FMODE = 3;
  localparam int CFG_SMODE = 5;
  localparam logic [7:0] CFG_RST = 8'h00;

  localparam int CMD_START = 0;
  localparam int CMD_ZERO  = 1;

  typedef enum logic [1:0] {PRE_OFF, PRE_ON, PRE_LEARN, PRE_PER_TRANSACTION_LEARN_MODE} pre_mode_t;

  typedef enum logic [3:0] {
    ST_IDLE, ST_PLAN, ST_READY, ST_FSET, ST_FAST, ST_SSET, ST_SLOW, ST_CHECK, ST_DUMP
  } fill_state_t;

endpackage : fill_pkg

/* hw/tick_if.sv */
// Tick strobes passed from the divider to the fill controller
interface tick_if;
  logic t05; // 0.05 s strobe
  logic t10; // 0.1 s strobe
  modport src (output t05, t10);
  modport dst (input t05, t10);
endinterface : tick_if

/* hw/tick_gen.sv */
// Divider making the 0.05 s and 0.1 s strobes
module tick_gen #(
  parameter int TICK05_CYC = fill_pkg::TICK05_CYC
) (
  input  logic sys_clk, // System clock
  input  logic srst,    // Synchronous reset
  tick_if.src  tk       // Strobes out
);

  localparam int CW = $clog2(TICK05_CYC);

  logic [CW-1:0] div_q;
  logic [3:0]    sub_q;
  logic          t05_q;
  logic          t10_q;
  logic          wrap;

  if (TICK05_CYC < 2) begin : g_chk
    $error("tick period too short");
  end

  assign wrap = (div_q == CW'(TICK05_CYC - 1));

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      div_q <= '0;
      t05_q <= 1'b0;
    end else begin
      div_q <= wrap ? '0 : div_q + 1'b1;
      t05_q <= wrap;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sub_q <= '0;
      t10_q <= 1'b0;
    end else begin
      t10_q <= wrap && (sub_q == 4'(fill_pkg::T10_PER_T05 - 1));
      if (wrap) begin
        sub_q <= (sub_q == 4'(fill_pkg::T10_PER_T05 - 1)) ? '0 : sub_q + 1'b1;
      end
    end
  end

  assign tk.t05 = t05_q;
  assign tk.t10 = t10_q;

  a_tick_pair: assert property (
    @(posedge sys_clk) disable iff (srst) t10_q |-> t05_q)
    else $error("slow tick without fast tick");

  a_tick_gap: assert property (
    @(posedge sys_clk) disable iff (srst) t05_q |=> !t05_q)
    else $error("fast tick longer than one cycle");

endmodule : tick_gen

/* hw/bulk_draft_fill_control.sv */
// Draft planning, zero offset and preact fill gate control for a weigh hopper
// What this block does
// - With level inputs enabled, each draft runs empty level to full level.
// - Shown gross weight is reading minus zero reference plus zero offset.
// - Zeroing with no keyed entry changes only the zero reference; with one waiting, only the zero offset.
// - Offset loads from keyed entry plus zero key, or remote offset write.
// - Drafts come from target and draft size, fewest drafts within draft size.
// - A too-small remainder turns the split into equal drafts, raised to the minimum only when trade-legal.
// - Industrial setting: drafts as equal as possible, even if below the minimum.
// - Trade-legal setting: all drafts but the last meet the minimum.
// - Fast and slow fill keep separate early-close settings.
// - Fast mode off: fast gate closes at the draft weight itself, or at draft minus slow band when two-speed.
// - Fast mode on: fast gate closes early by the time or weight amount.
// - Fast learn: start from setting, nudge up or down per draft result.
// - Per_transaction_learn_mode: as learn, but setting restored at each transaction start.
// - Time setting: close weight from time and last second's flow rate.
// - Weight amount alone: close at draft minus amount; ignored if timed.
// - After fast gate opens, weight checks wait the fast settle count of 0.1 s ticks.
// - Slow early-close applies only to the final draft.
// - Slow mode off: slow gate closes at the draft weight.
// - Slow mode on: slow gate closes early by the slow weight amount.
// - Slow learn: start from slow amount, nudge per final draft result.
// - After slow gate opens, weight checks wait the slow settle count of 0.1 s ticks.
//
// Our own choices: the strobed register port and the register addresses.
module bulk_draft_fill_control #(
  parameter int W          = 24,
  parameter int TICK05_CYC = fill_pkg::TICK05_CYC,
  parameter int LEARN_STEP = 1
) (
  input  logic                sys_clk,                  // System clock
  input  logic                srst,                     // Synchronous reset
  input  logic [7:0]          reg_addr,                 // Register byte address
  input  logic [31:0]         reg_wdata,                // Write data
  input  logic                reg_wr,                   // Write strobe
  input  logic                reg_rd,                   // Read strobe
  output logic [31:0]         reg_rdata,                // Read data, cycle after strobe
  input  logic signed [W-1:0] scale_weight,             // Raw scale reading
  input  logic                dump_done,                // Hopper emptied pulse
  input  logic                hopper_full_level_input,  // Full level pin
  input  logic                hopper_empty_level_input, // Empty level pin
  output logic                fast_gate,                // Fast fill gate open
  output logic                slow_gate,                // Slow fill gate open
  output logic signed [W+1:0] gross_weight              // Shown gross weight
);

  typedef logic [W-1:0]        wt_t;
  typedef logic signed [W+1:0] swt_t;

  if (W < 8 || W > 29) begin : g_chk
    $error("weight width out of range");
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  tick_if tk ();

  tick_gen #(.TICK05_CYC(TICK05_CYC)) u_tick (
    .sys_clk (sys_clk),
    .srst    (srst),
    .tk      (tk.src)
  );

  logic full_m_q, full_s_q, empty_m_q, empty_s_q;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      full_m_q  <= 1'b0;
      full_s_q  <= 1'b0;
      empty_m_q <= 1'b0;
      empty_s_q <= 1'b0;
    end else begin
      full_m_q  <= hopper_full_level_input;
      full_s_q  <= full_m_q;
      empty_m_q <= hopper_empty_level_input;
      empty_s_q <= empty_m_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  function automatic wt_t cdiv(input wt_t a, input wt_t b);
    logic [W:0] s;
    s = {1'b0, a} + {1'b0, b} - 1'b1;
    if (b == '0) return wt_t'(1);
    return wt_t'(s / {1'b0, b});
  endfunction : cdiv

  function automatic wt_t nudge(input wt_t v, input logic up, input logic dn, input wt_t st);
    if (up) return v + st;
    if (dn) return (v > st) ? v - st : '0;
    return v;
  endfunction : nudge

  function automatic logic wr_at(input logic [7:0] a);
    return reg_wr && (reg_addr == a);
  endfunction : wr_at

  ////////////////////////////////////////////////////////////////////////////////////////////////
  logic [7:0]  cfg_q, fint_q, fset_q, sset_q, fast_int_q, nleft_q, tcnt_q;
  wt_t         tgt_q, dsz_q, min_q, sband_q, fval_q, sval_q, zoff_q, entry_q;
  wt_t         fast_amt_q, slow_amt_q, each_q, last_q, acc_q;
  logic signed [W-1:0] zero_ref_q;
  logic        entry_v_q;
  swt_t        gross_q, start_q, sec_q, rate_q;
  logic [4:0]  secn_q;
  logic        fast_gate_q, slow_gate_q;
  logic [31:0] rdata_q;
  fill_pkg::fill_state_t state_q, state_d;
  fill_pkg::pre_mode_t   fmode, smode;
  logic        lvl_en, legal, two, cmd_start, cmd_zero, is_last, over, under, fin, judge;
  swt_t        fill_wt, cur_tgt, fast_pre, slow_pre, fast_thr, slow_thr, timed;
  wt_t         n_c, rem_c, eqv_c, each_c, last_c;

  assign lvl_en    = cfg_q[fill_pkg::CFG_LEVEL];
  assign legal     = cfg_q[fill_pkg::CFG_LEGAL];
  assign two       = cfg_q[fill_pkg::CFG_TWO];
  assign fmode     = fill_pkg::pre_mode_t'(cfg_q[fill_pkg::CFG_FMODE +: 2]);
  assign smode     = fill_pkg::pre_mode_t'(cfg_q[fill_pkg::CFG_SMODE +: 2]);
  assign cmd_start = wr_at(fill_pkg::A_CMD) && reg_wdata[fill_pkg::CMD_START];
  assign cmd_zero  = wr_at(fill_pkg::A_CMD) && reg_wdata[fill_pkg::CMD_ZERO];

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cfg_q   <= fill_pkg::CFG_RST;
      tgt_q   <= '0;
      dsz_q   <= '0;
      min_q   <= '0;
      sband_q <= '0;
      fval_q  <= '0;
      sval_q  <= '0;
      fint_q  <= '0;
      fset_q  <= '0;
      sset_q  <= '0;
    end else begin
      if (wr_at(fill_pkg::A_CFG))     cfg_q   <= reg_wdata[7:0];
      if (wr_at(fill_pkg::A_TARGET))  tgt_q   <= reg_wdata[W-1:0];
      if (wr_at(fill_pkg::A_DRAFT))   dsz_q   <= reg_wdata[W-1:0];
      if (wr_at(fill_pkg::A_MINDR))   min_q   <= reg_wdata[W-1:0];
      if (wr_at(fill_pkg::A_SBAND))   sband_q <= reg_wdata[W-1:0];
      if (wr_at(fill_pkg::A_FVAL))    fval_q  <= reg_wdata[W-1:0];
      if (wr_at(fill_pkg::A_SVAL))    sval_q  <= reg_wdata[W-1:0];
      if (wr_at(fill_pkg::A_FINT))    fint_q  <= reg_wdata[7:0];
      if (wr_at(fill_pkg::A_FSETTLE)) fset_q  <= reg_wdata[7:0];
      if (wr_at(fill_pkg::A_SSETTLE)) sset_q  <= reg_wdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Zero reference, keyed entry and zero offset
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      zero_ref_q <= '0;
      zoff_q     <= '0;
      entry_q    <= '0;
      entry_v_q  <= 1'b0;
    end else begin
      if (wr_at(fill_pkg::A_KEYENT)) begin
        entry_q   <= reg_wdata[W-1:0];
        entry_v_q <= 1'b1;
      end
      if (wr_at(fill_pkg::A_ZOFF)) begin
        zoff_q <= reg_wdata[W-1:0];
      end
      if (cmd_zero && entry_v_q) begin
        zoff_q    <= entry_q;
        entry_v_q <= 1'b0;
      end else if (cmd_zero) begin
        zero_ref_q <= scale_weight;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      gross_q <= '0;
    end else begin
      gross_q <= swt_t'(scale_weight) - swt_t'(zero_ref_q) + swt_t'(zoff_q);
    end
  end

  // Flow over the last full second, sampled every twenty 0.05 s ticks
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      secn_q <= '0;
      sec_q  <= '0;
      rate_q <= '0;
    end else if (tk.t05) begin
      secn_q <= (secn_q == 5'(fill_pkg::T05_PER_SEC - 1)) ? '0 : secn_q + 1'b1;
      if (secn_q == 5'(fill_pkg::T05_PER_SEC - 1)) begin
        sec_q  <= gross_q;
        rate_q <= gross_q - sec_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Draft split
  always_comb begin
    n_c    = cdiv(tgt_q, dsz_q);
    rem_c  = tgt_q - wt_t'((n_c - 1'b1) * dsz_q);
    eqv_c  = cdiv(tgt_q, n_c);
    each_c = dsz_q;
    last_c = rem_c;
    if (n_c > wt_t'(1) && rem_c < min_q) begin
      each_c = eqv_c;
      if (legal && eqv_c < min_q) each_c = min_q;
      last_c = tgt_q - wt_t'((n_c - 1'b1) * each_c);
    end
  end

  assign is_last = (nleft_q == 8'h01) && !lvl_en;
  assign cur_tgt = swt_t'(is_last ? last_q : each_q);
  assign fill_wt = gross_q - start_q;
  assign over    = fill_wt > cur_tgt;
  assign under   = fill_wt < cur_tgt;
  assign timed   = swt_t'((rate_q * swt_t'(fmode == fill_pkg::PRE_ON ? fint_q : fast_int_q))
                   / fill_pkg::T05_PER_SEC);

  always_comb begin
    if (fmode == fill_pkg::PRE_OFF) fast_pre = '0;
    else if (fint_q != 8'h00) fast_pre = timed;
    else if (fmode == fill_pkg::PRE_ON) fast_pre = swt_t'(fval_q);
    else fast_pre = swt_t'(fast_amt_q);
    if (smode == fill_pkg::PRE_OFF || !is_last) slow_pre = '0;
    else if (smode == fill_pkg::PRE_ON) slow_pre = swt_t'(sval_q);
    else slow_pre = swt_t'(slow_amt_q);
  end

  assign fast_thr = cur_tgt - (two ? swt_t'(sband_q) : swt_t'(0)) - fast_pre;
  assign slow_thr = cur_tgt - slow_pre;
  assign fin      = lvl_en ? (acc_q >= tgt_q) : (nleft_q == 8'h00);
  assign judge    = (state_q == fill_pkg::ST_CHECK) && tk.t10;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_d = state_q;
    case (state_q)
      fill_pkg::ST_IDLE:  if (cmd_start) state_d = fill_pkg::ST_PLAN;
      fill_pkg::ST_PLAN:  state_d = fill_pkg::ST_READY;
      fill_pkg::ST_READY: if (!lvl_en || empty_s_q) state_d = fill_pkg::ST_FSET;
      fill_pkg::ST_FSET:  if (tcnt_q == 8'h00) state_d = fill_pkg::ST_FAST;
      fill_pkg::ST_FAST: begin
        if (lvl_en ? full_s_q : (fill_wt >= fast_thr)) begin
          state_d = (two && !lvl_en) ? fill_pkg::ST_SSET : fill_pkg::ST_CHECK;
        end
      end
      fill_pkg::ST_SSET:  if (tcnt_q == 8'h00) state_d = fill_pkg::ST_SLOW;
      fill_pkg::ST_SLOW:  if (fill_wt >= slow_thr) state_d = fill_pkg::ST_CHECK;
      fill_pkg::ST_CHECK: if (tk.t10) state_d = fill_pkg::ST_DUMP;
      fill_pkg::ST_DUMP: begin
        if (lvl_en ? empty_s_q : dump_done) begin
          state_d = fin ? fill_pkg::ST_IDLE : fill_pkg::ST_READY;
        end
      end
      default: state_d = fill_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_q     <= fill_pkg::ST_IDLE;
      fast_gate_q <= 1'b0;
      slow_gate_q <= 1'b0;
    end else begin
      state_q     <= state_d;
      fast_gate_q <= (state_d == fill_pkg::ST_FSET) || (state_d == fill_pkg::ST_FAST);
      slow_gate_q <= (state_d == fill_pkg::ST_SSET) || (state_d == fill_pkg::ST_SLOW);
    end
  end

  // Settle count only steps on free-running ticks, so the first unit may be short
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      tcnt_q <= '0;
    end else if (state_d == fill_pkg::ST_FSET && state_q != fill_pkg::ST_FSET) begin
      tcnt_q <= fset_q;
    end else if (state_d == fill_pkg::ST_SSET && state_q != fill_pkg::ST_SSET) begin
      tcnt_q <= sset_q;
    end else if (tk.t10 && tcnt_q != 8'h00) begin
      tcnt_q <= tcnt_q - 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      each_q  <= '0;
      last_q  <= '0;
      nleft_q <= '0;
      acc_q   <= '0;
      start_q <= '0;
    end else begin
      if (state_q == fill_pkg::ST_PLAN) begin
        each_q  <= each_c;
        last_q  <= last_c;
        nleft_q <= (n_c > wt_t'(255)) ? 8'hff : n_c[7:0];
        acc_q   <= '0;
      end
      if (state_d == fill_pkg::ST_FSET && state_q != fill_pkg::ST_FSET) start_q <= gross_q;
      if (judge) begin
        acc_q <= acc_q + fill_wt[W-1:0];
        if (nleft_q != 8'h00) nleft_q <= nleft_q - 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Learned early-close amounts, judged one settle tick after the gates close
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      fast_amt_q <= '0;
      fast_int_q <= '0;
      slow_amt_q <= '0;
    end else begin
      if (wr_at(fill_pkg::A_FVAL)) fast_amt_q <= reg_wdata[W-1:0];
      if (wr_at(fill_pkg::A_FINT)) fast_int_q <= reg_wdata[7:0];
      if (wr_at(fill_pkg::A_SVAL)) slow_amt_q <= reg_wdata[W-1:0];
      if (cmd_start && state_q == fill_pkg::ST_IDLE && fmode == fill_pkg::PRE_PER_TRANSACTION_LEARN_MODE) begin
        fast_amt_q <= fval_q;
        fast_int_q <= fint_q;
      end
      if (judge && !lvl_en && fmode[1]) begin
        if (fint_q != 8'h00) begin
          if (!(over && fast_int_q == 8'hff)) begin
            fast_int_q <= 8'(nudge(wt_t'(fast_int_q), over, under, wt_t'(1)));
          end
        end else begin
          fast_amt_q <= nudge(fast_amt_q, over, under, wt_t'(LEARN_STEP));
        end
      end
      if (judge && is_last && smode[1]) begin
        slow_amt_q <= nudge(slow_amt_q, over, under, wt_t'(LEARN_STEP));
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk) begin
    if (srst || !reg_rd) begin
      rdata_q <= '0;
    end else begin
      case (reg_addr)
        fill_pkg::A_CFG:     rdata_q <= 32'(cfg_q);
        fill_pkg::A_TARGET:  rdata_q <= 32'(tgt_q);
        fill_pkg::A_DRAFT:   rdata_q <= 32'(dsz_q);
        fill_pkg::A_MINDR:   rdata_q <= 32'(min_q);
        fill_pkg::A_FINT:    rdata_q <= 32'(fint_q);
        fill_pkg::A_FVAL:    rdata_q <= 32'(fval_q);
        fill_pkg::A_SBAND:   rdata_q <= 32'(sband_q);
        fill_pkg::A_SVAL:    rdata_q <= 32'(sval_q);
        fill_pkg::A_FSETTLE: rdata_q <= 32'(fset_q);
        fill_pkg::A_SSETTLE: rdata_q <= 32'(sset_q);
        fill_pkg::A_ZOFF:    rdata_q <= 32'(zoff_q);
        fill_pkg::A_KEYENT:  rdata_q <= 32'(entry_q);
        fill_pkg::A_STATUS:  rdata_q <= {16'h0000, nleft_q, 1'b0, entry_v_q, empty_s_q,
                                         full_s_q, state_q};
        fill_pkg::A_GROSS:   rdata_q <= 32'(gross_q);
        fill_pkg::A_EACH:    rdata_q <= 32'(each_q);
        fill_pkg::A_LAST:    rdata_q <= 32'(last_q);
        fill_pkg::A_FLEARN:  rdata_q <= {fast_int_q, 24'(fast_amt_q)};
        fill_pkg::A_SLEARN:  rdata_q <= 32'(slow_amt_q);
        fill_pkg::A_ACC:     rdata_q <= 32'(acc_q);
        default:             rdata_q <= '0;
      endcase
    end
  end

  assign reg_rdata    = rdata_q;
  assign fast_gate    = fast_gate_q;
  assign slow_gate    = slow_gate_q;
  assign gross_weight = gross_q;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  sequence s_fast_open;
    !fast_gate_q ##1 fast_gate_q;
  endsequence

  sequence s_fast_close;
    state_q == fill_pkg::ST_FAST ##1 state_q != fill_pkg::ST_FAST;
  endsequence

  a_level_draft: assert property (
    lvl_en && state_q == fill_pkg::ST_FAST |=>
      (state_q == fill_pkg::ST_CHECK) == $past(full_s_q))
    else $error("volume draft not ended by full level");

  a_gross_sum: assert property (
    1'b1 |=> gross_q == $past(swt_t'(scale_weight) - swt_t'(zero_ref_q) + swt_t'(zoff_q)))
    else $error("gross weight wrong");

  a_zero_keeps: assert property (
    cmd_zero && !entry_v_q |=> $stable(zoff_q) && zero_ref_q == $past(scale_weight))
    else $error("zeroing disturbed offset");

  a_offset_entry: assert property (
    wr_at(fill_pkg::A_ZOFF) && !cmd_zero |=> zoff_q == $past(reg_wdata[W-1:0]))
    else $error("remote offset not taken");

  a_plan_sum: assert property (
    state_q == fill_pkg::ST_PLAN && n_c < wt_t'(256) |=>
      wt_t'((wt_t'(nleft_q) - 1'b1) * each_q) + last_q == tgt_q)
    else $error("drafts do not add to target");

  a_legal_min: assert property (
    state_q == fill_pkg::ST_PLAN && legal && dsz_q >= min_q && n_c > wt_t'(1) |=>
      each_q >= min_q)
    else $error("legal draft below minimum");

  a_fast_off: assert property (
    s_fast_close ##0 (fmode == fill_pkg::PRE_OFF && !two && !lvl_en) |->
      $past(fill_wt) >= $past(cur_tgt))
    else $error("fast gate closed early with mode off");

  a_fast_settle: assert property (
    s_fast_open ##0 (fset_q != 8'h00) |-> state_q == fill_pkg::ST_FSET [*2])
    else $error("weight check during fast settle");

  a_slow_last: assert property (
    state_q == fill_pkg::ST_SLOW && !is_last && fill_wt < cur_tgt |=>
      state_q == fill_pkg::ST_SLOW)
    else $error("slow preact off the final draft");

  a_per_transaction_learn_mode_load: assert property (
    cmd_start && state_q == fill_pkg::ST_IDLE && fmode == fill_pkg::PRE_PER_TRANSACTION_LEARN_MODE |=>
      fast_amt_q == $past(fval_q) && fast_int_q == $past(fint_q))
    else $error("per_transaction_learn_mode did not restore setting");

endmodule : bulk_draft_fill_control

/* dv/hopper_model.sv */
// Behavioural hopper: gates pour material, level pins, dump after idle
module hopper_model #(
  parameter int RATE = 5
) (
  input  wire logic               sys_clk,   // System clock
  input  wire logic               srst,      // Sync reset
  input  wire logic               fast_gate, // Fast gate open
  input  wire logic               slow_gate, // Slow gate open
  input  wire logic signed [23:0] bias,      // Stuck material
  output logic signed [23:0]      scale,     // Scale reading
  output logic                    dump_done, // Hopper emptied
  output logic                    full_lvl,  // Full level
  output logic                    empty_lvl  // Empty level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic signed [23:0] fill_q;
  logic [5:0]         idle_q;
  // Slow gate pours one unit a cycle, fast gate RATE units
  always_ff @(posedge sys_clk) begin
    if (srst || dump_done) fill_q <= '0;
    else fill_q <= fill_q + (fast_gate ? 24'(RATE) : 24'(slow_gate));
    idle_q <= (srst || fast_gate || slow_gate || fill_q == 0) ? '0 : idle_q + 6'h01;
  end
  assign dump_done = &idle_q;
  assign scale     = fill_q + bias;
  assign full_lvl  = fill_q >= 24'sd900;
  assign empty_lvl = fill_q == 24'sd0;
endmodule : hopper_model

/* dv/tb_bulk_draft_fill_control.sv */
// Self-checking bench for the bulk draft fill controller
module tb_bulk_draft_fill_control;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [31:0] tgt, drf, mn, cfg, each, last;} row_t;
  row_t rows[4] = '{'{90000, 60000, 40000, 0, 45000, 45000},
                    '{70000, 60000, 40000, 0, 35000, 35000},
                    '{70000, 60000, 40000, 2, 40000, 30000},
                    '{120000, 60000, 40000, 0, 60000, 60000}};
  logic               sys_clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0]         reg_addr = 8'h00;
  logic [31:0]        reg_wdata = 32'h0, reg_rdata, d;
  logic signed [23:0] bias = 24'sh0, scale;
  logic               fast_gate, slow_gate, dump_done, full_lvl, empty_lvl;
  logic signed [25:0] gross_weight;
  int                 n_fail = 0, cmp_count = 0;
  int                 lo[5] = '{1000, 975, 900, 990, 975}, hi[5] = '{1030, 999, 930, 999, 999};
  logic [31:0]        cf[5] = '{32'h00, 32'h08, 32'h01, 32'h24, 32'h18};
  always #5 sys_clk = ~sys_clk;
  bulk_draft_fill_control #(.TICK05_CYC(4)) i_bulk_draft_fill_control (.sys_clk(sys_clk),
    .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .scale_weight(scale), .dump_done(dump_done),
    .hopper_full_level_input(full_lvl), .hopper_empty_level_input(empty_lvl),
    .fast_gate(fast_gate), .slow_gate(slow_gate), .gross_weight(gross_weight));
  hopper_model i_hopper_model (.sys_clk(sys_clk), .srst(srst), .fast_gate(fast_gate),
    .slow_gate(slow_gate), .bias(bias), .scale(scale), .dump_done(dump_done),
    .full_lvl(full_lvl), .empty_lvl(empty_lvl));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    if (n_fail == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rst(input int n);
    @(posedge sys_clk);
    srst <= 1'b1;
    repeat (n) @(posedge sys_clk);
    srst <= 1'b0;
  endtask : rst
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  // Gates are looked at on the falling edge, away from the edge that launches them
  task automatic wait_gate(input logic sel, input logic lvl);
    int k;
    k = 0;
    while ((sel ? slow_gate : fast_gate) !== lvl && k < 2000) begin
      @(negedge sys_clk);
      k++;
    end
    if (k == 2000) chk(32'(sel ? slow_gate : fast_gate), 32'(lvl));
  endtask : wait_gate
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    wrap_up();
  end
  initial begin
    rst(20);
    rd(fill_pkg::A_CFG);
    chk(d, 32'h0);
    rd(8'hfc);
    chk(d, 32'h0);
    foreach (rows[i]) begin
      rst(2);
      wr(fill_pkg::A_CFG, rows[i].cfg);
      wr(fill_pkg::A_TARGET, rows[i].tgt);
      wr(fill_pkg::A_DRAFT, rows[i].drf);
      wr(fill_pkg::A_MINDR, rows[i].mn);
      wr(fill_pkg::A_CMD, 32'h1);
      repeat (4) @(posedge sys_clk);
      rd(fill_pkg::A_EACH);
      chk(d, rows[i].each);
      rd(fill_pkg::A_LAST);
      chk(d, rows[i].last);
    end
    rst(2);
    wr(fill_pkg::A_ZOFF, 32'd100);
    bias <= 24'sd3;
    wr(fill_pkg::A_CMD, 32'h2);
    bias <= 24'sh0;
    repeat (3) @(posedge sys_clk);
    #1 chk(32'(gross_weight), 32'd97);
    wr(fill_pkg::A_KEYENT, 32'd50);
    wr(fill_pkg::A_CMD, 32'h2);
    repeat (3) @(posedge sys_clk);
    #1 chk(32'(gross_weight), 32'd47);
    // Mode off, mode on, volume fill, two-speed with slow preact, per_transaction_learn_mode
    for (int m = 0; m < 5; m++) begin
      rst(2);
      wr(fill_pkg::A_CFG, cf[m]);
      wr(fill_pkg::A_TARGET, 32'd1000);
      wr(fill_pkg::A_FVAL, 32'd25);
      wr(fill_pkg::A_SBAND, 32'd100);
      wr(fill_pkg::A_SVAL, 32'd10);
      wr(fill_pkg::A_FSETTLE, 32'd1);
      wr(fill_pkg::A_CMD, 32'h1);
      wait_gate(1'b0, 1'b1);
      wait_gate(1'b0, 1'b0);
      chk(32'(slow_gate), 32'(m == 3));
      wait_gate(1'b1, 1'b0);
      repeat (4) @(posedge sys_clk);
      #1 chk(32'(scale >= lo[m] && scale <= hi[m]), 32'h1);
      repeat (8) @(posedge sys_clk);
      rd(fill_pkg::A_FLEARN);
      chk(d, (m == 4) ? 32'h18 : 32'h19);
    end
    wrap_up();
  end
endmodule : tb_bulk_draft_fill_control
